//--- rtl/bms_boot_mode_selector.sv
`timescale 1ns/1ps
module bms_boot_mode_selector
   import bms_pkg::*;
#(
   parameter logic [BMS_ADDR_W-1:0] SIG_ADDR0 = 24'h000100,
   parameter logic [BMS_ADDR_W-1:0] SIG_ADDR1 = 24'h000102,
   parameter logic [BMS_ADDR_W-1:0] KEY_ADDR = 24'h000104,
   parameter logic [15:0] SIG_REF = 16'hFFFF,
   parameter logic [15:0] KEY_STD = 16'h0001,
   parameter logic [15:0] KEY_UART = 16'h0002,
   parameter logic [15:0] KEY_CAN = 16'h0003
) (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic EXT_RESET_N_I,
   input wire logic [BMS_CFG_W-1:0] CONFIG_PORT_LOW_I,
   input wire logic UART_RX_I,
   input wire logic CAN_RX_I,
   input wire logic FLASH_ACK_I,
   input wire logic [15:0] FLASH_DATA_I,
   output bms_flash_req_type FLASH_REQ_O,
   output logic [BMS_CFG_W-1:0] CONFIG_LATCHED_O,
   output logic [BMS_ADDR_W-1:0] FETCH_BASE_O,
   output bms_status_type STATUS_O
);
   logic rst_meta;
   logic rst_n;
   logic ext_prev;
   bms_state_type state;
   bms_state_type next_state;
   logic [BMS_CFG_W-1:0] cfg;
   logic [BMS_CFG_W-1:0] next_cfg;
   logic [15:0] word0;
   logic [15:0] next_word0;
   logic uart_en;
   logic can_en;
   logic next_uart_en;
   logic next_can_en;
   bms_status_type stat;
   bms_status_type next_stat;
   logic uart_hit;
   logic can_hit;
   logic ext_rise;

   // signature: sum of the two reserved words
   function automatic logic sig_ok(input logic [15:0] a, input logic [15:0] b);
      return 16'(a + b) == SIG_REF;
   endfunction

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // external reset taken as synchronous; latch on its rise only
   assign ext_rise = EXT_RESET_N_I && !ext_prev;

   bms_chan_det u_det (
      .clk_i(CLOCK_I),
      .rst_n_i(rst_n),
      .ce_i(CE_I),
      .arm_i(state == BMS_SCAN),
      .uart_en_i(uart_en),
      .can_en_i(can_en),
      .uart_rx_i(UART_RX_I),
      .can_rx_i(CAN_RX_I),
      .uart_hit_o(uart_hit),
      .can_hit_o(can_hit)
   );

   always_comb begin
      next_state = state;
      next_cfg = cfg;
      next_word0 = word0;
      next_uart_en = uart_en;
      next_can_en = can_en;
      next_stat = stat;
      FLASH_REQ_O.req = 1'b0;
      FLASH_REQ_O.addr = BMS_BOOT_ADDR;
      if (!EXT_RESET_N_I) begin
         next_state = BMS_IDLE;
      end else if (ext_rise) begin
         next_cfg = CONFIG_PORT_LOW_I;
         next_stat = '0;
         next_uart_en = 1'b1;
         next_can_en = 1'b1;
         unique case ({CONFIG_PORT_LOW_I[BMS_PIN_HI], CONFIG_PORT_LOW_I[BMS_PIN_LO]})
            BMS_CODE_USER: begin
               next_state = BMS_USER;
               next_stat.user_mode = 1'b1;
               next_stat.data_user_flash = 1'b1;
            end
            BMS_CODE_STD: begin
               next_state = BMS_SCAN;
               next_stat.code_test_flash = 1'b1;
               next_stat.data_user_flash = 1'b1;
            end
            BMS_CODE_SEL: begin
               next_state = BMS_RD0;
               next_stat.code_test_flash = 1'b1;
               next_stat.data_user_flash = 1'b1;
            end
            default: begin
               next_state = BMS_LOOP;
               next_stat.reserved_code = 1'b1;
               next_stat.endless_loop = 1'b1;
            end
         endcase
      end else begin
         unique case (state)
            BMS_IDLE, BMS_USER, BMS_UART, BMS_CAN, BMS_LOOP: begin
            end
            BMS_SCAN: begin
               if (uart_hit) begin
                  next_state = BMS_UART;
                  next_stat.uart_loader = 1'b1;
               end else if (can_hit) begin
                  next_state = BMS_CAN;
                  next_stat.can_loader = 1'b1;
               end
            end
            BMS_RD0: begin
               FLASH_REQ_O.req = 1'b1;
               FLASH_REQ_O.addr = SIG_ADDR0;
               if (FLASH_ACK_I) begin
                  next_word0 = FLASH_DATA_I;
                  next_state = BMS_RD1;
               end
            end
            BMS_RD1: begin
               FLASH_REQ_O.req = 1'b1;
               FLASH_REQ_O.addr = SIG_ADDR1;
               if (FLASH_ACK_I) begin
                  if (sig_ok(word0, FLASH_DATA_I)) begin
                     next_state = BMS_SRST;
                     next_stat.sw_reset = 1'b1;
                  end else begin
                     next_state = BMS_RDKEY;
                  end
               end
            end
            BMS_RDKEY: begin
               FLASH_REQ_O.req = 1'b1;
               FLASH_REQ_O.addr = KEY_ADDR;
               if (FLASH_ACK_I) begin
                  if (FLASH_DATA_I == KEY_STD) begin
                     next_state = BMS_SCAN;
                  end else if (FLASH_DATA_I == KEY_UART) begin
                     next_state = BMS_SCAN;
                     next_can_en = 1'b0;
                  end else if (FLASH_DATA_I == KEY_CAN) begin
                     next_state = BMS_SCAN;
                     next_uart_en = 1'b0;
                  end else begin
                     next_state = BMS_LOOP;
                     next_stat.endless_loop = 1'b1;
                  end
               end
            end
            // after the reset sequence user code runs from user flash
            BMS_SRST: begin
               next_state = BMS_USER;
               next_stat.sw_reset = 1'b0;
               next_stat.user_mode = 1'b1;
               next_stat.code_test_flash = 1'b0;
            end
            default: begin
               next_state = BMS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         // idle level of the pin, so no false rise follows reset
         ext_prev <= 1'b1;
         state <= BMS_IDLE;
         cfg <= '0;
         word0 <= '0;
         uart_en <= 1'b0;
         can_en <= 1'b0;
         stat <= '0;
      end else if (CE_I) begin
         ext_prev <= EXT_RESET_N_I;
         state <= next_state;
         cfg <= next_cfg;
         word0 <= next_word0;
         uart_en <= next_uart_en;
         can_en <= next_can_en;
         stat <= next_stat;
      end
   end

   assign CONFIG_LATCHED_O = cfg;
   assign STATUS_O = stat;
   // both flash maps start at zero; the status bits say which array serves fetches
   assign FETCH_BASE_O = BMS_BOOT_ADDR;
endmodule // bms_boot_mode_selector

//--- shared/bms_pkg.sv
// What this block does
// - capture config port low bits 5 and 4 at external reset rising edge
// - code 11: user mode, user flash at address zero for code and data
// - code 10: standard loader, code fetches from test flash, user flash readable
// - code 01: selective boot, code fetches to test flash, extra checks decide
// - standard loader watches uart and can one receive lines for first event
// - uart start condition first selects uart loader; host sends it
// - valid dominant can bit first selects can loader; host drives it
// - selective boot computes signature from two flash words, compares with reference
// - signature pass: software reset sequence then user code
// - signature fail: read user key location to decide behaviour
// - key picks standard loader, uart only, can only, or endless loop
package bms_pkg;
   localparam int BMS_ADDR_W = 24;
   localparam logic [BMS_ADDR_W-1:0] BMS_BOOT_ADDR = 24'h000000;
   localparam int BMS_CFG_W = 16;
   localparam int BMS_PIN_HI = 5;
   localparam int BMS_PIN_LO = 4;
   localparam logic [1:0] BMS_CODE_USER = 2'h3;
   localparam logic [1:0] BMS_CODE_STD = 2'h2;
   localparam logic [1:0] BMS_CODE_SEL = 2'h1;
   // dominant bit must stay low this many ns to count as valid
   localparam int BMS_CAN_VALID_NS = 80;
   localparam int BMS_CLK_NS = 8;
   localparam int BMS_CAN_VALID_CYC = (BMS_CAN_VALID_NS + BMS_CLK_NS - 1) / BMS_CLK_NS;
   localparam int BMS_CNT_W = 8;

   typedef enum logic [9:0] {
      BMS_IDLE   = 10'h001,
      BMS_USER   = 10'h002,
      BMS_SCAN   = 10'h004,
      BMS_UART   = 10'h008,
      BMS_CAN    = 10'h010,
      BMS_RD0    = 10'h020,
      BMS_RD1    = 10'h040,
      BMS_RDKEY  = 10'h080,
      BMS_SRST   = 10'h100,
      BMS_LOOP   = 10'h200
   } bms_state_type;

   typedef struct packed {
      logic user_mode;
      logic code_test_flash;
      logic data_user_flash;
      logic sw_reset;
      logic uart_loader;
      logic can_loader;
      logic endless_loop;
      logic reserved_code;
   } bms_status_type;

   typedef struct packed {
      logic req;
      logic [BMS_ADDR_W-1:0] addr;
   } bms_flash_req_type;
endpackage

//--- rtl/bms_chan_det.sv
`timescale 1ns/1ps
module bms_chan_det
   import bms_pkg::*;
#(
   parameter int VALID_CYC = BMS_CAN_VALID_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic arm_i,
   input wire logic uart_en_i,
   input wire logic can_en_i,
   input wire logic uart_rx_i,
   input wire logic can_rx_i,
   output logic uart_hit_o,
   output logic can_hit_o
);
   logic uart_prev;
   logic [BMS_CNT_W-1:0] can_cnt;
   logic next_uart_prev;
   logic [BMS_CNT_W-1:0] next_can_cnt;

   always_comb begin
      next_uart_prev = uart_rx_i;
      next_can_cnt = '0;
      if (arm_i && can_en_i && !can_rx_i && !can_hit_o) begin
         next_can_cnt = can_cnt + BMS_CNT_W'(1);
      end
   end

   assign uart_hit_o = arm_i && uart_en_i && uart_prev && !uart_rx_i;
   assign can_hit_o = arm_i && can_en_i && !can_rx_i
      && (can_cnt >= BMS_CNT_W'(VALID_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uart_prev <= 1'b1;
         can_cnt <= '0;
      end else if (ce_i) begin
         uart_prev <= next_uart_prev;
         can_cnt <= next_can_cnt;
      end
   end
endmodule // bms_chan_det

//--- dv/bms_props.sv
`timescale 1ns/1ps
module bms_props
   import bms_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic EXT_RESET_N_I,
   input wire logic [BMS_CFG_W-1:0] CONFIG_PORT_LOW_I,
   input wire logic UART_RX_I,
   input wire logic CAN_RX_I,
   input wire logic FLASH_ACK_I,
   input wire logic [15:0] FLASH_DATA_I,
   input wire bms_flash_req_type FLASH_REQ_O,
   input wire logic [BMS_CFG_W-1:0] CONFIG_LATCHED_O,
   input wire logic [BMS_ADDR_W-1:0] FETCH_BASE_O,
   input wire bms_status_type STATUS_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   logic [7:0] low_cnt;
   logic [7:0] next_low_cnt;
   // saturates so a long dominant level never wraps back below the filter
   always_comb begin
      next_low_cnt = CAN_RX_I ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
   end
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end
   sequence rise_s(logic [1:0] c);
      CE_I && $rose(EXT_RESET_N_I) && CONFIG_PORT_LOW_I[BMS_PIN_HI:BMS_PIN_LO] == c;
   endsequence
   sequence srst_s;
      !STATUS_O.sw_reset ##[0:2] STATUS_O.user_mode;
   endsequence
   a_cfg_capture: assert property (
      CE_I && $rose(EXT_RESET_N_I) |=> CONFIG_LATCHED_O == $past(CONFIG_PORT_LOW_I))
      else $error("config word not latched");
   a_user_mode: assert property (
      rise_s(BMS_CODE_USER) |=> STATUS_O.user_mode && !STATUS_O.code_test_flash)
      else $error("user mode not entered");
   a_std_mode: assert property (
      rise_s(BMS_CODE_STD) |=> STATUS_O.code_test_flash && STATUS_O.data_user_flash)
      else $error("standard loader mapping wrong");
   a_sel_mode: assert property (
      rise_s(BMS_CODE_SEL) |=> STATUS_O.code_test_flash && !STATUS_O.user_mode)
      else $error("selective boot mapping wrong");
   a_reserved_code: assert property (
      rise_s(2'h0) |=> STATUS_O.reserved_code && STATUS_O.endless_loop)
      else $error("reserved code not trapped");
   a_boot_base: assert property (
      FETCH_BASE_O == BMS_BOOT_ADDR)
      else $error("fetch base moved");
   a_uart_start: assert property (
      $rose(STATUS_O.uart_loader) |-> $past(UART_RX_I, 2) && !$past(UART_RX_I))
      else $error("uart loader without start edge");
   a_can_valid: assert property (
      $rose(STATUS_O.can_loader) |-> $past(next_low_cnt) >= 8'(BMS_CAN_VALID_CYC))
      else $error("can loader on short dominant");
   a_one_path: assert property (
      $onehot0({STATUS_O.uart_loader, STATUS_O.can_loader, STATUS_O.endless_loop,
                STATUS_O.user_mode}))
      else $error("more than one boot path");
   a_srst_user: assert property (
      $rose(STATUS_O.sw_reset) |=> srst_s)
      else $error("software reset not followed by user code");
   a_req_hold: assert property (
      FLASH_REQ_O.req && !FLASH_ACK_I && EXT_RESET_N_I
      |=> !EXT_RESET_N_I || (FLASH_REQ_O.req && $stable(FLASH_REQ_O.addr)))
      else $error("flash request dropped early");
endmodule // bms_props
bind bms_boot_mode_selector bms_props u_props (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I),
   .CE_I(CE_I), .EXT_RESET_N_I(EXT_RESET_N_I), .CONFIG_PORT_LOW_I(CONFIG_PORT_LOW_I),
   .UART_RX_I(UART_RX_I), .CAN_RX_I(CAN_RX_I), .FLASH_ACK_I(FLASH_ACK_I),
   .FLASH_DATA_I(FLASH_DATA_I), .FLASH_REQ_O(FLASH_REQ_O),
   .CONFIG_LATCHED_O(CONFIG_LATCHED_O), .FETCH_BASE_O(FETCH_BASE_O), .STATUS_O(STATUS_O));

//--- dv/bms_flash_model.sv
`timescale 1ns/1ps
module bms_flash_model
   import bms_pkg::*;
(
   input wire logic clk_i,
   input wire bms_flash_req_type req_i,
   input wire logic [2:0] lat_i,
   input wire logic [15:0] word0_i,
   input wire logic [15:0] word1_i,
   input wire logic [15:0] key_i,
   output logic ack_o,
   output logic [15:0] data_o
);
   logic [2:0] cnt = 3'h0;
   logic [2:0] next_cnt;
   logic [15:0] junk = 16'hA5C3;
   always_comb begin
      ack_o = req_i.req && cnt >= lat_i;
      next_cnt = (req_i.req && !ack_o) ? cnt + 3'h1 : 3'h0;
      case (req_i.addr)
         24'h000100: data_o = word0_i;
         24'h000102: data_o = word1_i;
         24'h000104: data_o = key_i;
         default: data_o = ~junk;
      endcase
      // idle bus moves every cycle so a stale word cannot pass
      if (!ack_o) data_o = junk;
   end
   always_ff @(posedge clk_i) begin
      cnt <= next_cnt;
      junk <= junk + 16'h3B5D;
   end
endmodule // bms_flash_model

//--- dv/bms_boot_mode_selector_test.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s expected %h seen %h", n, e, g); end end
module bms_boot_mode_selector_test;
   import bms_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ext_n = 1'b1;
   logic uart = 1'b1;
   logic can = 1'b1;
   logic ack;
   logic [15:0] cfg = 16'h0000, fdata, cfg_q, w0 = 16'h0000, w1 = 16'h0000, key = 16'h0000;
   logic [2:0] lat = 3'h0;
   logic [31:0] lfsr = 32'hF3D3;
   logic [23:0] fbase;
   bms_flash_req_type req;
   bms_status_type st;
   logic [32:0] exp_q[$];
   logic [15:0] kv[4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0007};
   logic [15:0] e1[4] = '{16'h0004, 16'h0000, 16'h0000, 16'h0002};
   logic [15:0] e2[4] = '{16'h0004, 16'h0008, 16'h0004, 16'h0002};
   int bad_count = 0, n_compared = 0, tn = 0, n_ack = 0;
   event chk;
   always #4 clk = ~clk;
   bms_boot_mode_selector dut (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .EXT_RESET_N_I(ext_n),
      .CONFIG_PORT_LOW_I(cfg), .UART_RX_I(uart), .CAN_RX_I(can), .FLASH_ACK_I(ack),
      .FLASH_DATA_I(fdata), .FLASH_REQ_O(req), .CONFIG_LATCHED_O(cfg_q),
      .FETCH_BASE_O(fbase), .STATUS_O(st));
   bms_flash_model flash (.clk_i(clk), .req_i(req), .lat_i(lat), .word0_i(w0), .word1_i(w1),
      .key_i(key), .ack_o(ack), .data_o(fdata));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic report_and_stop;
      $display("test %0d ended", tn);
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic note(input logic k, input logic [15:0] m, input logic [15:0] e);
      exp_q.push_back({k, m, e});
      -> chk;
   endtask
   always @(chk) begin : watch
      logic [32:0] x;
      // two notes in one time step wake this only once, so drain them all
      while (exp_q.size() > 0) begin
         x = exp_q.pop_front();
         `CHK(x[32] ? "status" : "config", (x[32] ? {8'h00, st} : cfg_q) & x[31:16],
            x[15:0])
         `CHK("fetch base", fbase, BMS_BOOT_ADDR)
      end
   end
   // each flash answer stands one cycle, so count them where they are settled
   always @(negedge clk) begin
      if (ack === 1'b1) n_ack++;
   end
   task automatic boot(input logic [1:0] c, input logic [15:0] a, input logic [15:0] k);
      if (tn > 0) $display("test %0d ended", tn);
      tn++;
      lfsr = nxt(lfsr);
      ext_n = 1'b0;
      n_ack = 0;
      w0 = a;
      w1 = 16'h0000 - a;
      key = k;
      lat = lfsr[2:0] & 3'h3;
      step(3);
      cfg = {lfsr[15:6], c, lfsr[3:0]};
      ext_n = 1'b1;
      step(2);
      note(1'b0, 16'hFFFF, cfg);
   endtask
   task automatic ufall;
      uart = 1'b0;
      step(2);
      uart = 1'b1;
   endtask
   task automatic cflt(input int n);
      can = 1'b0;
      step(n);
      can = 1'b1;
      step(1);
   endtask
   task automatic acks(input int n);
      for (int i = 0; i < 200 && n_ack < n; i++) begin
         step(1);
      end
      if (n_ack < n) begin
         bad_count++;
         report_and_stop();
      end else begin
         step(2);
      end
   endtask
   initial begin
      #800000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      step(12);
      nrst = 1'b1;
      step(4);
      boot(BMS_CODE_USER, 16'h0000, 16'h0000);
      note(1'b1, 16'h00C0, 16'h0080);
      boot(2'h0, 16'h0000, 16'h0000);
      note(1'b1, 16'h0003, 16'h0003);
      boot(BMS_CODE_STD, 16'h0000, 16'h0000);
      note(1'b1, 16'h0060, 16'h0060);
      cflt(9);
      note(1'b1, 16'h000C, 16'h0000);
      ufall();
      note(1'b1, 16'h000C, 16'h0008);
      boot(BMS_CODE_STD, 16'h0000, 16'h0000);
      cflt(10);
      note(1'b1, 16'h000C, 16'h0004);
      lfsr = nxt(lfsr);
      boot(BMS_CODE_SEL, lfsr[15:0] | 16'h0001, 16'h0000);
      w1 = ~w0;
      note(1'b1, 16'h00C0, 16'h0040);
      acks(2);
      step(4);
      note(1'b1, 16'h008E, 16'h0080);
      for (int i = 0; i < 4; i++) begin
         boot(BMS_CODE_SEL, 16'h1234, kv[i]);
         acks(3);
         if (i == 2) ufall();
         else cflt(12);
         note(1'b1, 16'h000E, e1[i]);
         if (i == 2) cflt(12);
         else ufall();
         note(1'b1, 16'h000E, e2[i]);
      end
      step(2);
      report_and_stop();
   end
endmodule // bms_boot_mode_selector_test
